// ==== core/ulc_pkg.sv ====
// Package for the UART line control and status block: register map,
// field positions, reset values, frame timing and bus carrier types.
// Assumes a 32-bit AXI4-Lite master and one core clock.
`default_nettype none
package ulc_pkg;
  // Register byte addresses
  localparam logic [31:0] ULC_ADDR_SHARED = 32'hffff0700;
  localparam logic [31:0] ULC_ADDR_IEN = 32'hffff0704;
  localparam logic [31:0] ULC_ADDR_IID = 32'hffff0708;
  localparam logic [31:0] ULC_ADDR_LCR = 32'hffff070c;
  localparam logic [31:0] ULC_ADDR_AUX = 32'hffff0710;
  localparam logic [31:0] ULC_ADDR_LSR = 32'hffff0714;
  localparam logic [31:0] ULC_ADDR_CDIV = 32'hffff0718;
  // Line control fields, then the auxiliary loop back bit
  localparam int ULC_LCR_DIVISOR_ACCESS_BIT = 7;
  localparam int ULC_LCR_BRK = 6;
  localparam int ULC_LCR_SP = 5;
  localparam int ULC_LCR_EPS = 4;
  localparam int ULC_LCR_PEN = 3;
  localparam int ULC_LCR_STOP = 2;
  localparam int ULC_AUX_LOOP = 4;
  // Interrupt enable fields
  localparam int ULC_IEN_LINE_STATUS_INT_ENABLE = 2;
  localparam int ULC_IEN_TX_EMPTY_INT_ENABLE = 1;
  localparam int ULC_IEN_RX_FULL_INT_ENABLE = 0;
  // Reset values
  localparam logic [7:0] ULC_RST_IID = 8'h01;
  localparam logic [7:0] ULC_RST_LSR = 8'h60;
  localparam logic [7:0] ULC_RST_CTRL = 8'h00;
  // Receive source codes
  localparam logic [1:0] ULC_SRC_LIN = 2'h0;
  localparam logic [1:0] ULC_SRC_GP = 2'h2;
  // Identification codes
  localparam logic [1:0] ULC_ID_LS = 2'h3;
  localparam logic [1:0] ULC_ID_RXF = 2'h2;
  localparam logic [1:0] ULC_ID_TXE = 2'h1;
  localparam logic [1:0] ULC_ID_NONE = 2'h0;
  // Frame timing in oversample ticks (16 per bit)
  localparam logic [5:0] ULC_BIT_LAST = 6'h0f;
  localparam logic [5:0] ULC_HALF_LAST = 6'h07;
  localparam logic [5:0] ULC_STOP15_LAST = 6'h17;
  localparam logic [5:0] ULC_STOP2_LAST = 6'h1f;
  // Longest frame: start, 8 data, parity, 2 stop = 12 bits
  localparam logic [7:0] ULC_BREAK_TICKS = 8'hc0;
  // Bus answers
  localparam logic [1:0] ULC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ULC_RESP_SLVERR = 2'h2;
  // Carrier types
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] prot;
  } ulc_addr_t;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } ulc_wdata_t;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } ulc_rdata_t;
  // Serial state machines
  typedef enum logic [4:0] {
    ULC_SER_IDLE = 5'h01,
    ULC_SER_START = 5'h02,
    ULC_SER_DATA = 5'h04,
    ULC_SER_PAR = 5'h08,
    ULC_SER_STOP = 5'h10
  } ulc_ser_t;
endpackage
`default_nettype wire

// ==== core/ulc_uart.sv ====
// UART line control, line status and interrupt identification with its
// own transmitter, receiver and baud generator behind an AXI4-Lite slave.
// Assumes serial inputs synchronous to aclk and a well-behaved master.
// Operation
// [RULE1] Divisor access bit steers shared locations to divisor bytes.
// [RULE2] Break control forces the transmit output low.
// [RULE3] Stick parity sends and checks constant parity equal to even select.
// [RULE4] Even parity select picks even when set, odd when clear.
// [RULE5] Parity enable adds and checks a parity bit per character.
// [RULE6] Length field gives 5 to 8 bits; stop select gives 1.5 or 2.
// [RULE7] Receiver checks only the first stop bit.
// [RULE8] Source field picks LIN receiver for 00, general pin for 10.
// [RULE9] Loop back mode holds the transmit output high.
// [RULE10] Transmit empty flag follows holding register, clears on write.
// [RULE11] Holding empty flag set when transmit and receive both empty.
// [RULE12] Break flag set when input low beyond longest character.
// [RULE13] Framing error on bad stop bit, parity error on mismatch.
// [RULE14] Overrun set when unread character is overwritten.
// [RULE15] Data ready set on character, cleared by reading receive data.
// [RULE16] Line status enable raises interrupt on error or ready events.
// [RULE17] Transmit empty enable raises interrupt when buffer empties.
// [RULE18] Receive full enable raises interrupt when character arrives.
// [RULE19] Ident bit 0 high when idle; line status code 11 first.
// [RULE20] Receive full reported as code 10, cleared by data read.
// [RULE21] Transmit empty code 01, cleared by data write or ident read.
// [RULE22] Pending code 00 is never reported.
// [RULE23] Tick rate is clock over two to divider, 2, and divisor.
// [RULE24] Data and low divisor share one address chosen by access bit.
// [RULE25] Frame: low start, data LSB first, parity, high stops.
`default_nettype none
module ulc_uart
  import ulc_pkg::*;
#(
  parameter int unsigned BAUD_CNT_W = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ulc_addr_t s_axi_aw,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire ulc_wdata_t s_axi_w,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire ulc_addr_t s_axi_ar,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output ulc_rdata_t s_axi_r,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lin_rx_in,
  input wire logic general_pin_five,
  output logic txd,
  output logic uart_irq
);
  // Divisor 16 bits shifted by up to 7, doubled, needs 24 bits
  if (BAUD_CNT_W < 24) begin : g_chk
    $error("BAUD_CNT_W must be at least 24");
  end

  typedef struct packed {
    logic aw_got;
    logic [31:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    ulc_rdata_t r;
    logic [7:0] lcr;
    logic [7:0] aux;
    logic [2:0] ien;
    logic [7:0] dll;
    logic [7:0] dlm;
    logic [2:0] cd;
    logic [BAUD_CNT_W-1:0] baud_cnt;
    logic tick;
    logic [7:0] thr;
    logic thr_full;
    ulc_ser_t tx_st;
    logic [5:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic txd;
    ulc_ser_t rx_st;
    logic [5:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic [7:0] rbr;
    logic dr;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic [7:0] low_cnt;
    logic ls_int;
    logic holding_regs_empty_flag_int;
    logic irq;
  } ulc_state_t;

  ulc_state_t s;
  ulc_state_t n;

  logic divisor_access_bit;
  logic loop;
  logic break_control;
  logic [1:0] word_length_field;
  logic [2:0] last_bit;
  logic [7:0] mask;
  logic [5:0] stop_last;
  logic [BAUD_CNT_W-1:0] limit;
  logic tx_line;
  logic rx_in;
  logic rx_done;
  logic wr_go;
  logic rd_go;
  logic wr_thr;
  logic rd_rbr;
  logic ls_pend;
  logic rxf_pend;
  logic txe_pend;
  logic [7:0] iid_val;
  logic [7:0] lsr_val;
  logic [7:0] rd_val;
  logic rd_hit;

  // Parity bit for a character of the configured length
  function automatic logic par_of(input logic [7:0] d,
                                  input logic [7:0] lcr_v,
                                  input logic [7:0] m);
    logic p;
    p = ^(d & m);
    if (lcr_v[ULC_LCR_SP]) begin
      return lcr_v[ULC_LCR_EPS]; // RULE3
    end
    return lcr_v[ULC_LCR_EPS] ? p : ~p; // RULE4
  endfunction

  // Frame format decode
  assign divisor_access_bit = s.lcr[ULC_LCR_DIVISOR_ACCESS_BIT];
  assign loop = s.aux[ULC_AUX_LOOP];
  assign break_control = s.lcr[ULC_LCR_BRK];
  assign word_length_field = s.lcr[1:0];
  assign last_bit = 3'h4 + {1'b0, word_length_field}; // RULE6
  assign mask = 8'hff >> (2'h3 - word_length_field);
  assign stop_last = !s.lcr[ULC_LCR_STOP] ? ULC_BIT_LAST :
                     (word_length_field == 2'h0) ? ULC_STOP15_LAST : ULC_STOP2_LAST; // RULE6
  // Oversample period: 2^cd * 2 * divisor core cycles; the shift sum
  // is kept 4 bits wide so cd 7 does not wrap to a shift of zero
  assign limit = BAUD_CNT_W'({s.dlm, s.dll}) <<
                 ({1'b0, s.cd} + 4'h1); // RULE23

  // Line level of the transmitter before break and loop back
  always_comb begin
    unique case (s.tx_st)
      ULC_SER_START: tx_line = 1'b0; // RULE25
      ULC_SER_DATA: tx_line = s.tx_sh[0];
      ULC_SER_PAR: tx_line = s.tx_par;
      default: tx_line = 1'b1;
    endcase
  end

  // Receive source; reserved codes read an idle line
  always_comb begin
    if (loop) begin
      rx_in = break_control ? 1'b0 : tx_line;
    end else if (s.aux[7:6] == ULC_SRC_LIN) begin
      rx_in = lin_rx_in; // RULE8
    end else if (s.aux[7:6] == ULC_SRC_GP) begin
      rx_in = general_pin_five; // RULE8
    end else begin
      rx_in = 1'b1;
    end
  end

  // Bus strobes and side-effect decode
  assign wr_go = s.aw_got && s.w_got && !s.bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_thr = wr_go && s.w_lane0 && !divisor_access_bit &&
                  s.aw_addr == ULC_ADDR_SHARED; // RULE1
  assign rd_rbr = rd_go && !divisor_access_bit && s_axi_ar.addr == ULC_ADDR_SHARED;
  assign rx_done = s.tick && s.rx_st == ULC_SER_STOP &&
                   s.rx_cnt == ULC_BIT_LAST;

  // Interrupt priority and identification
  assign ls_pend = s.ien[ULC_IEN_LINE_STATUS_INT_ENABLE] && s.ls_int; // RULE16
  assign rxf_pend = s.ien[ULC_IEN_RX_FULL_INT_ENABLE] && s.dr; // RULE18
  assign txe_pend = s.ien[ULC_IEN_TX_EMPTY_INT_ENABLE] && s.holding_regs_empty_flag_int; // RULE17
  always_comb begin
    if (ls_pend) begin
      iid_val = {5'h00, ULC_ID_LS, 1'b0}; // RULE19
    end else if (rxf_pend) begin
      iid_val = {5'h00, ULC_ID_RXF, 1'b0}; // RULE20
    end else if (txe_pend) begin
      iid_val = {5'h00, ULC_ID_TXE, 1'b0}; // RULE21
    end else begin
      iid_val = {5'h00, ULC_ID_NONE, 1'b1}; // RULE22
    end
  end
  assign lsr_val = {1'b0, !s.thr_full, !s.thr_full && !s.dr, // RULE10 RULE11
                    s.bi, s.fe, s.pe, s.oe, s.dr};

  // Read mux; shared locations follow the divisor access bit
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_ar.addr)
      ULC_ADDR_SHARED: rd_val = divisor_access_bit ? s.dll : s.rbr; // RULE24
      ULC_ADDR_IEN: rd_val = divisor_access_bit ? s.dlm : {5'h00, s.ien}; // RULE1
      ULC_ADDR_IID: rd_val = iid_val;
      ULC_ADDR_LCR: rd_val = s.lcr;
      ULC_ADDR_AUX: rd_val = s.aux;
      ULC_ADDR_LSR: rd_val = lsr_val;
      ULC_ADDR_CDIV: rd_val = {5'h00, s.cd};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  // One read in flight; a new one waits until the answer is taken
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_r = s.r;
  assign txd = s.txd;
  assign uart_irq = s.irq;

  // Next state; clears come before sets so a same-cycle event wins
  always_comb begin
    n = s;
    n.tick = 1'b0;
    // Bus write channel
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_aw.addr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_w.data[7:0];
      n.w_lane0 = s_axi_w.strb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = ULC_RESP_OKAY;
      if (s.w_lane0) begin
        unique case (s.aw_addr)
          ULC_ADDR_SHARED: begin
            if (divisor_access_bit) begin
              n.dll = s.w_data; // RULE1
            end else begin
              n.thr = s.w_data;
              n.thr_full = 1'b1; // RULE10
              n.holding_regs_empty_flag_int = 1'b0; // RULE21
            end
          end
          ULC_ADDR_IEN: begin
            if (divisor_access_bit) begin
              n.dlm = s.w_data;
            end else begin
              n.ien = s.w_data[2:0];
            end
          end
          ULC_ADDR_LCR: n.lcr = s.w_data;
          ULC_ADDR_AUX: n.aux = s.w_data;
          ULC_ADDR_CDIV: n.cd = s.w_data[2:0];
          ULC_ADDR_IID, ULC_ADDR_LSR: n.bresp = ULC_RESP_OKAY;
          default: n.bresp = ULC_RESP_SLVERR;
        endcase
      end else if (!(s.aw_addr inside {ULC_ADDR_SHARED, ULC_ADDR_IEN,
          ULC_ADDR_IID, ULC_ADDR_LCR, ULC_ADDR_AUX, ULC_ADDR_LSR,
          ULC_ADDR_CDIV})) begin
        n.bresp = ULC_RESP_SLVERR;
      end
    end
    // Bus read channel with read side effects
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.r.data = {24'h000000, rd_val};
      n.r.resp = rd_hit ? ULC_RESP_OKAY : ULC_RESP_SLVERR;
      if (rd_rbr) begin
        n.dr = 1'b0; // RULE15 RULE20
      end
      if (s_axi_ar.addr == ULC_ADDR_LSR) begin
        n.bi = 1'b0; // RULE12
        n.fe = 1'b0; // RULE13
        n.pe = 1'b0;
        n.oe = 1'b0; // RULE14
        n.ls_int = 1'b0; // RULE19
      end
      if (s_axi_ar.addr == ULC_ADDR_IID && !ls_pend && !rxf_pend) begin
        n.holding_regs_empty_flag_int = 1'b0; // RULE21
      end
    end
    // Baud tick; a zero divisor stops the line
    if (limit == '0) begin
      n.baud_cnt = '0;
    end else if (s.baud_cnt >= limit - BAUD_CNT_W'(1)) begin
      n.baud_cnt = '0;
      n.tick = 1'b1; // RULE23
    end else begin
      n.baud_cnt = s.baud_cnt + BAUD_CNT_W'(1);
    end
    // Transmitter
    if (s.tick) begin
      n.tx_cnt = s.tx_cnt + 6'h01;
      unique case (s.tx_st)
        ULC_SER_IDLE: begin
          n.tx_cnt = 6'h00;
          if (s.thr_full) begin
            n.tx_sh = s.thr;
            n.tx_par = par_of(s.thr, s.lcr, mask); // RULE3 RULE4
            n.thr_full = wr_thr;
            n.holding_regs_empty_flag_int = 1'b1; // RULE17
            n.tx_st = ULC_SER_START; // RULE25
          end
        end
        ULC_SER_START: begin
          if (s.tx_cnt == ULC_BIT_LAST) begin
            n.tx_cnt = 6'h00;
            n.tx_bit = 3'h0;
            n.tx_st = ULC_SER_DATA;
          end
        end
        ULC_SER_DATA: begin
          if (s.tx_cnt == ULC_BIT_LAST) begin
            n.tx_cnt = 6'h00;
            n.tx_sh = s.tx_sh >> 1; // RULE25
            n.tx_bit = s.tx_bit + 3'h1;
            if (s.tx_bit == last_bit) begin
              n.tx_st = s.lcr[ULC_LCR_PEN] ? ULC_SER_PAR :
                        ULC_SER_STOP; // RULE5
            end
          end
        end
        ULC_SER_PAR: begin
          if (s.tx_cnt == ULC_BIT_LAST) begin
            n.tx_cnt = 6'h00;
            n.tx_st = ULC_SER_STOP;
          end
        end
        ULC_SER_STOP: begin
          if (s.tx_cnt == stop_last) begin
            n.tx_st = ULC_SER_IDLE; // RULE6
          end
        end
      endcase
    end
    // Pin driver: loop back keeps the line idle, break pulls it low
    n.txd = loop ? 1'b1 : break_control ? 1'b0 : tx_line; // RULE2 RULE9
    // Receiver, sampling at bit centres
    if (s.tick) begin
      n.rx_cnt = s.rx_cnt + 6'h01;
      unique case (s.rx_st)
        ULC_SER_IDLE: begin
          n.rx_cnt = 6'h00;
          if (!rx_in) begin
            n.rx_st = ULC_SER_START;
          end
        end
        ULC_SER_START: begin
          // A start shorter than half a bit is taken as a glitch
          if (s.rx_cnt == ULC_HALF_LAST) begin
            n.rx_cnt = 6'h00;
            n.rx_bit = 3'h0;
            n.rx_st = rx_in ? ULC_SER_IDLE : ULC_SER_DATA;
          end
        end
        ULC_SER_DATA: begin
          if (s.rx_cnt == ULC_BIT_LAST) begin
            n.rx_cnt = 6'h00;
            n.rx_sh = {rx_in, s.rx_sh[7:1]}; // RULE25
            n.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == last_bit) begin
              n.rx_st = s.lcr[ULC_LCR_PEN] ? ULC_SER_PAR :
                        ULC_SER_STOP; // RULE5
            end
          end
        end
        ULC_SER_PAR: begin
          if (s.rx_cnt == ULC_BIT_LAST) begin
            n.rx_cnt = 6'h00;
            n.rx_par = rx_in;
            n.rx_st = ULC_SER_STOP;
          end
        end
        ULC_SER_STOP: begin
          // Only the first stop bit is looked at
          if (s.rx_cnt == ULC_BIT_LAST) begin
            n.rx_st = ULC_SER_IDLE; // RULE7
          end
        end
      endcase
    end
    if (rx_done) begin
      n.rbr = s.rx_sh >> (2'h3 - word_length_field);
      // Built on n so a status read in this cycle still clears old errors
      n.oe = n.oe || (s.dr && !rd_rbr); // RULE14
      n.dr = 1'b1; // RULE15
      n.fe = n.fe || !rx_in; // RULE13
      n.pe = n.pe || (s.lcr[ULC_LCR_PEN] && s.rx_par !=
             par_of(s.rx_sh >> (2'h3 - word_length_field), s.lcr, mask)); // RULE13
      n.ls_int = 1'b1; // RULE16
    end
    // Break detector counts ticks of continuous low input
    if (s.tick) begin
      if (rx_in) begin
        n.low_cnt = 8'h00;
      end else if (s.low_cnt != 8'hff) begin
        n.low_cnt = s.low_cnt + 8'h01;
      end
      if (!rx_in && s.low_cnt == ULC_BREAK_TICKS) begin
        n.bi = 1'b1; // RULE12
      end
    end
    n.irq = ls_pend || rxf_pend || txe_pend;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.lcr <= ULC_RST_CTRL;
      s.aux <= ULC_RST_CTRL;
      s.tx_st <= ULC_SER_IDLE;
      s.rx_st <= ULC_SER_IDLE;
      s.txd <= 1'b1;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_brk;
    break_control && !loop |=> txd == 1'b0;
  endproperty
  a_brk: assert property (p_brk) else $error("break not driving low"); // RULE2
  property p_loop;
    loop |=> txd;
  endproperty
  a_loop: assert property (p_loop) else $error("loop back not high"); // RULE9
  property p_stick;
    s.tx_st == ULC_SER_PAR && s.lcr[ULC_LCR_SP] |->
      tx_line == s.lcr[ULC_LCR_EPS];
  endproperty
  a_stick: assert property (p_stick) else $error("stick parity wrong"); // RULE3
  property p_src;
    !loop && s.aux[7:6] == ULC_SRC_GP |-> rx_in == general_pin_five;
  endproperty
  a_src: assert property (p_src) else $error("receive source wrong"); // RULE8
  property p_tx_empty_flag;
    wr_thr |=> !lsr_val[6] && !lsr_val[5];
  endproperty
  a_tx_empty_flag: assert property (p_tx_empty_flag) else $error("empty flag stays set"); // RULE10
  property p_dr;
    rd_rbr && !rx_done |=> !s.dr;
  endproperty
  a_dr: assert property (p_dr) else $error("data ready not cleared"); // RULE15
  property p_oe;
    rx_done && s.dr && !rd_rbr |=> s.oe && s.dr;
  endproperty
  a_oe: assert property (p_oe) else $error("overrun missed"); // RULE14
  property p_noreserved;
    !(iid_val[0] == 1'b0 && iid_val[2:1] == ULC_ID_NONE);
  endproperty
  a_noreserved: assert property (p_noreserved) else $error("code 00 pending"); // RULE22
  property p_prio;
    ls_pend |-> iid_val[2:0] == 3'h6 ##1 s.irq;
  endproperty
  a_prio: assert property (p_prio) else $error("line status priority"); // RULE19
  property p_stop2;
    s.tick && s.tx_st == ULC_SER_STOP && s.lcr[ULC_LCR_STOP] &&
      word_length_field != 2'h0 && s.tx_cnt < ULC_STOP2_LAST |=>
      s.tx_st == ULC_SER_STOP;
  endproperty
  a_stop2: assert property (p_stop2) else $error("stop too short"); // RULE6
endmodule // ulc_uart
`default_nettype wire

// ==== bench/ulc_remote.sv ====
// Remote serial station model: sends frames on the LIN or general pin
// line and captures frames from the transmit line.
// Assumes BIT_CYC aclk cycles per bit; both lines idle high.
`default_nettype none
module ulc_remote #(
  parameter int BIT_CYC = 32
) (
  input wire logic aclk,
  input wire logic txd,
  output var logic lin_rx_in,
  output var logic general_pin_five
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both lines rest high like a pulled-up bus
  initial begin
    lin_rx_in = 1'b1;
    general_pin_five = 1'b1;
  end
  // Hold one level on the chosen line for n cycles
  task automatic drive(input logic v, input int n, input logic on_gp);
    if (on_gp) general_pin_five <= v;
    else lin_rx_in <= v;
    repeat (n) @(posedge aclk);
  endtask
  // One stop bit only, so back-to-back calls leave no idle bit between
  task automatic send(input logic [7:0] d, input int nb, input logic parity_enable,
                      input logic par, input logic stp, input logic on_gp);
    @(posedge aclk);
    drive(1'b0, BIT_CYC, on_gp);
    for (int i = 0; i < nb; i++) begin
      drive(d[i], BIT_CYC, on_gp);
    end
    if (parity_enable) drive(par, BIT_CYC, on_gp);
    drive(stp, BIT_CYC, on_gp);
    drive(1'b1, 0, on_gp);
  endtask
  // Sample each bit of the next frame at its centre, stop bit included
  task automatic recv(output logic [9:0] d, input int nb);
    d = '0;
    while (txd !== 1'b1) @(posedge aclk);
    while (txd !== 1'b0) @(posedge aclk);
    repeat (BIT_CYC / 2) @(posedge aclk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CYC) @(posedge aclk);
      d[i] = txd;
    end
  endtask
endmodule // ulc_remote
`default_nettype wire

// ==== bench/uart_line_control_status_test.sv ====
// Self-checking bench: frame format, receive flags, interrupt ident
// and reset values. Assumes divisor 1, cd 0: 32 aclk cycles per bit.
`default_nettype none
module uart_line_control_status_test;
  import ulc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  ulc_addr_t aw = '0;
  ulc_addr_t ar = '0;
  ulc_wdata_t w = '0;
  ulc_rdata_t r;
  ulc_rdata_t q;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic awr, wrdy, bv, arr, rv, txd, irq, lin, gp;
  logic [1:0] bresp;
  logic [9:0] got;
  logic [9:0] got2;
  int num_errors = 0;
  int total_checks = 0;
  // Transmit rows: line control, data, bits captured, expected bits
  logic [7:0] t_lcr [7] = '{8'h03, 8'h1b, 8'h0b, 8'h3a, 8'h2a, 8'h00, 8'h07};
  logic [7:0] t_dat [7] = '{8'ha5, 8'ha5, 8'ha5, 8'h55, 8'h55, 8'h35, 8'h5a};
  int t_nb [7] = '{9, 10, 10, 9, 9, 6, 10};
  logic [9:0] t_exp [7] = '{10'h1a5, 10'h2a5, 10'h3a5, 10'h1d5, 10'h155,
                            10'h035, 10'h35a};
  // Reset rows; the last address is unmapped
  logic [31:0] r_adr [8] = '{ULC_ADDR_IEN, ULC_ADDR_IID, ULC_ADDR_LCR,
    ULC_ADDR_AUX, ULC_ADDR_LSR, ULC_ADDR_SHARED, ULC_ADDR_CDIV,
    32'hffff0720};
  logic [7:0] r_val [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00,
    8'h00, 8'h00};

  always #5 aclk = ~aclk;

  ulc_uart dut (.aclk(aclk), .aresetn(aresetn), .s_axi_aw(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_w(w),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_ar(ar),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_r(r),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .lin_rx_in(lin),
    .general_pin_five(gp), .txd(txd), .uart_irq(irq));

  ulc_remote remote (.aclk(aclk), .txd(txd), .lin_rx_in(lin),
    .general_pin_five(gp));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  // Address and data go out together; each drops when its ready is seen
  task automatic wreg(input logic [31:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    aw <= '{addr: a, prot: 3'h0};
    w <= '{data: {24'h0, d}, strb: 4'h1};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv === 1'b1) begin
        done = 1'b1;
        br <= 1'b0;
        chk("bresp", 32'(ULC_RESP_OKAY), 32'(bresp));
      end
    end
  endtask
  task automatic rreg(input logic [31:0] a, output ulc_rdata_t d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    ar <= '{addr: a, prot: 3'h0};
    arv <= 1'b1;
    rr <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rv === 1'b1) begin
        done = 1'b1;
        rr <= 1'b0;
        d = r;
      end
    end
  endtask
  task automatic rchk(input logic [31:0] a, input logic [7:0] e,
                      input string n);
    ulc_rdata_t t;
    rreg(a, t);
    chk(n, {24'h0, e}, t.data);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Whole run is under 10000 cycles; a hang is stopped at 50000
  initial begin
    repeat (50000) @(posedge aclk);
    num_errors++;
    $display("[ERR] watchdog expected done seen timeout");
    stop_test();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Divisor 1, then check which registers the access bit exposes
    wreg(ULC_ADDR_LCR, 8'h83);
    wreg(ULC_ADDR_SHARED, 8'h01);
    wreg(ULC_ADDR_IEN, 8'h00);
    rchk(ULC_ADDR_SHARED, 8'h01, "div low");
    wreg(ULC_ADDR_LCR, 8'h03);
    wreg(ULC_ADDR_IEN, 8'h07);
    wreg(ULC_ADDR_LCR, 8'h83);
    rchk(ULC_ADDR_IEN, 8'h00, "div high");
    wreg(ULC_ADDR_LCR, 8'h03);
    rchk(ULC_ADDR_IEN, 8'h07, "int enable");
    $display("test setup done");
    // Frame formats
    for (int i = 0; i < 7; i++) begin
      repeat (40) @(posedge aclk);
      wreg(ULC_ADDR_LCR, t_lcr[i]);
      fork
        remote.recv(got, t_nb[i]);
        wreg(ULC_ADDR_SHARED, t_dat[i]);
      join
      chk("tx frame", 32'(t_exp[i]), 32'(got));
    end
    $display("test tx table done");
    // Back-to-back writes keep the holding register full
    repeat (40) @(posedge aclk);
    wreg(ULC_ADDR_LCR, 8'h03);
    fork
      begin
        remote.recv(got, 9);
        remote.recv(got2, 9);
      end
      begin
        wreg(ULC_ADDR_SHARED, 8'h96);
        wreg(ULC_ADDR_SHARED, 8'h3c);
        rchk(ULC_ADDR_LSR, 8'h00, "status full");
      end
    join
    chk("tx first", 32'h196, 32'(got));
    chk("tx second", 32'h13c, 32'(got2));
    chk("irq tx", 32'h1, 32'(irq));
    rchk(ULC_ADDR_IID, 8'h02, "ident tx");
    rchk(ULC_ADDR_IID, 8'h01, "ident idle");
    repeat (2) @(posedge aclk);
    chk("irq idle", 32'h0, 32'(irq));
    $display("test tx interrupt done");
    // Receive path, priorities and clearing reads
    wreg(ULC_ADDR_LCR, 8'h1b);
    remote.send(8'h3c, 8, 1'b1, 1'b0, 1'b1, 1'b0);
    rchk(ULC_ADDR_IID, 8'h06, "ident ls");
    chk("irq ls", 32'h1, 32'(irq));
    rchk(ULC_ADDR_LSR, 8'h41, "status ready");
    rchk(ULC_ADDR_IID, 8'h04, "ident rx");
    rchk(ULC_ADDR_SHARED, 8'h3c, "rx data");
    rchk(ULC_ADDR_IID, 8'h01, "ident clear");
    rchk(ULC_ADDR_LSR, 8'h60, "status empty");
    // Two stop bits set but frames sent with one: second overruns first
    wreg(ULC_ADDR_LCR, 8'h1f);
    remote.send(8'h3c, 8, 1'b1, 1'b0, 1'b1, 1'b0);
    remote.send(8'h5a, 8, 1'b1, 1'b0, 1'b1, 1'b0);
    rchk(ULC_ADDR_LSR, 8'h43, "status overrun");
    rchk(ULC_ADDR_SHARED, 8'h5a, "rx newest");
    remote.send(8'h3c, 8, 1'b1, 1'b1, 1'b1, 1'b0);
    rchk(ULC_ADDR_LSR, 8'h45, "status parity");
    rchk(ULC_ADDR_SHARED, 8'h3c, "rx parity");
    remote.send(8'h3c, 8, 1'b1, 1'b0, 1'b0, 1'b0);
    rchk(ULC_ADDR_LSR, 8'h49, "status framing");
    rchk(ULC_ADDR_SHARED, 8'h3c, "rx framing");
    // General pin selected: the LIN frame must be ignored
    wreg(ULC_ADDR_AUX, 8'h80);
    remote.send(8'h3c, 8, 1'b1, 1'b0, 1'b1, 1'b0);
    remote.send(8'h5a, 8, 1'b1, 1'b0, 1'b1, 1'b1);
    rchk(ULC_ADDR_LSR, 8'h41, "status source");
    rchk(ULC_ADDR_SHARED, 8'h5a, "rx source");
    remote.drive(1'b0, 450, 1'b1);
    remote.drive(1'b1, 40, 1'b1);
    rreg(ULC_ADDR_LSR, q);
    chk("break flag", 32'h10, q.data & 32'h10);
    rchk(ULC_ADDR_SHARED, 8'h00, "rx break");
    $display("test rx done");
    // Break forces the line low; loop back wins and holds it high
    wreg(ULC_ADDR_LCR, 8'h5b);
    repeat (4) @(posedge aclk);
    chk("txd break", 32'h0, 32'(txd));
    wreg(ULC_ADDR_AUX, 8'h90);
    repeat (4) @(posedge aclk);
    chk("txd loop", 32'h1, 32'(txd));
    wreg(ULC_ADDR_AUX, 8'h80);
    wreg(ULC_ADDR_LCR, 8'h1b);
    repeat (4) @(posedge aclk);
    chk("txd normal", 32'h1, 32'(txd));
    $display("test break done");
    // Second reset in mid-run, then reset values and the unmapped word
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk("txd reset", 32'h1, 32'(txd));
    chk("irq reset", 32'h0, 32'(irq));
    for (int i = 0; i < 8; i++) begin
      rreg(r_adr[i], q);
      chk("reset value", 32'(r_val[i]), q.data);
      chk("read resp", (i == 7) ? 32'h2 : 32'h0, 32'(q.resp));
    end
    wreg(ULC_ADDR_CDIV, 8'h05);
    rchk(ULC_ADDR_CDIV, 8'h05, "clock div");
    $display("test reset done");
    stop_test();
  end
endmodule // uart_line_control_status_test
`default_nettype wire
